// File: hw/ssc_regs.svh
// Register offsets, field positions, reset values and error codes of the spindle command checker.
// Assumes a single 32-bit AHB-Lite slave decoding word addresses.
`ifndef SSC_REGS_SVH
`define SSC_REGS_SVH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define SSC_OFF_PARAM 12'h000
`define SSC_OFF_ERR 12'h004
`define SSC_OFF_STAT 12'h008
`define SSC_OFF_MASK 12'h00c

// ****************************************************************
// Parameter register fields
// ****************************************************************
`define SSC_P_MACHINE_READY_USE 0
`define SSC_P_HIRES 1
`define SSC_P_BUILTIN 2
`define SSC_P_POSCODER 3
`define SSC_P_ORIENT_OPT 4
`define SSC_P_SWITCH_OPT 5
`define SSC_P_DIFF_SPEED 6
`define SSC_P_DET_LSB 8
`define SSC_PARAM_W 16
`define SSC_PARAM_RST 16'h0000
`define SSC_DET_128 8'h80

// ****************************************************************
// Status register fields
// ****************************************************************
`define SSC_S_NEWERR 0
`define SSC_S_CLEARED 1
`define SSC_STAT_W 2
`define SSC_MASK_RST 2'h0

// ****************************************************************
// Operation error codes
// ****************************************************************
`define SSC_ER_NONE 5'h00
`define SSC_ER_01 5'h01
`define SSC_ER_02 5'h02
`define SSC_ER_03 5'h03
`define SSC_ER_04 5'h04
`define SSC_ER_05 5'h05
`define SSC_ER_06 5'h06
`define SSC_ER_07 5'h07
`define SSC_ER_08 5'h08
`define SSC_ER_09 5'h09
`define SSC_ER_10 5'h0a
`define SSC_ER_11 5'h0b
`define SSC_ER_12 5'h0c
`define SSC_ER_13 5'h0d
`define SSC_ER_14 5'h0e
`define SSC_ER_15 5'h0f

`endif

// File: hw/ssc_pkg.sv
// Types shared by the spindle command checker.
// Assumes the register header supplies all numbers.
package ssc_pkg;
   // Bus data phase tracking
   typedef enum logic [1:0] {
      SSC_BUS_IDLE = 2'b00,
      SSC_BUS_WR = 2'b01,
      SSC_BUS_RD = 2'b10
   } ssc_bus_t;
endpackage : ssc_pkg

// File: hw/ssc_checker.sv
// Spindle command sequence checker: watches controller commands, reports operation errors.
// Assumes commands are synchronous to mclk and software reaches registers over AHB-Lite.
//
// Contract
// - Rotation without emergency-stop release or machine-ready raises error 01.
// - Machine-ready part of error 01 applies only when its parameter enables it.
// - Hi-res coder, non-built-in motor, detector not 128: refuse excitation, error 02.
// - Contour axis command without hi-res coder parameter: error 03, no excitation.
// - Servo or synchronous command without position coder parameter: error 04, no excitation.
// - Orientation without orientation option parameter raises error 05.
// - Low winding without output switchover option raises error 06.
// - Contour, servo, synchronous without rotation command raise errors 07, 08, 09.
// - Contour mode with servo, synchronous or orientation raises error 10.
// - Servo mode with contour, synchronous or orientation raises error 11.
// - Synchronous mode with contour, servo or orientation raises error 12.
// - Orientation with contour, servo or synchronous raises error 13.
// - Forward and reverse together raise error 14; controller sends only one.
// - Error codes go to the amplifier's own indicator and to the error register, not the controller.
`timescale 1ns/1ns
`include "ssc_regs.svh"
module ssc_checker
   import ssc_pkg::*;
(
   input wire logic mclk,
   input wire logic nrst,
   input wire logic fwd_rotate_cmd,
   input wire logic rev_rotate_cmd,
   input wire logic emerg_stop_n,
   input wire logic machine_ready,
   input wire logic contour_cmd,
   input wire logic servo_cmd,
   input wire logic sync_cmd,
   input wire logic orient_cmd,
   input wire logic low_winding_sel,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   output logic [4:0] amp_err_code,
   output logic amp_err_flag,
   output logic motor_excite_en,
   output logic irq
);

   // ****************************************************************
   // Error detection
   // ****************************************************************
   logic [`SSC_PARAM_W-1:0] param_ff;
   logic [4:0] err_code_ff;
   logic rotate_any;
   logic machine_ready_ok;
   logic [7:0] det_ppr;
   logic er01;
   logic er02;
   logic er03;
   logic er04;
   logic er05;
   logic er06;
   logic er07;
   logic er08;
   logic er09;
   logic er10;
   logic er11;
   logic er12;
   logic er13;
   logic er14;
   logic er15;
   logic no_excite;
   logic [4:0] nxt_err_code;

   // ****************************************************************
   // Mode ownership
   // ****************************************************************
   logic [3:0] mode_vec;
   logic [3:0] mode_prev_ff;
   logic [3:0] owner_ff;
   logic [3:0] held_vec;
   logic [3:0] pick_pool;
   logic [3:0] pick_one;
   logic [3:0] nxt_owner;
   logic clash;

   // Bit 0 contour, 1 servo, 2 synchronous, 3 orientation
   assign mode_vec = {orient_cmd, sync_cmd, servo_cmd, contour_cmd};
   // Two or more mode commands at once is a clash
   assign clash = ((mode_vec & (mode_vec - 4'h1)) != 4'h0);
   // A mode already commanded owns the clash; if none was, the lowest one does
   assign held_vec = mode_vec & mode_prev_ff;
   assign pick_pool = (held_vec != 4'h0) ? held_vec : mode_vec;
   assign pick_one = pick_pool & (~pick_pool + 4'h1);
   // Owner sticks while still commanded, so the code does not flip a cycle later
   assign nxt_owner = ~clash ? 4'h0 :
                      ((owner_ff & mode_vec) != 4'h0) ? owner_ff : pick_one;

   // Previous modes and current owner
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         mode_prev_ff <= 4'h0;
         owner_ff <= 4'h0;
      end else begin
         mode_prev_ff <= mode_vec;
         owner_ff <= nxt_owner;
      end
   end

   // Mode and sequence conditions, decoded from live inputs and parameters; errors 10 to 13 also use the registered owner
   assign rotate_any = fwd_rotate_cmd | rev_rotate_cmd;
   assign machine_ready_ok = machine_ready | ~param_ff[`SSC_P_MACHINE_READY_USE];
   assign det_ppr = param_ff[`SSC_P_DET_LSB +: 8];
   assign er01 = rotate_any & ~(emerg_stop_n & machine_ready_ok);
   assign er02 = param_ff[`SSC_P_HIRES] & ~param_ff[`SSC_P_BUILTIN] & (det_ppr != `SSC_DET_128);
   assign er03 = contour_cmd & ~param_ff[`SSC_P_HIRES];
   assign er04 = (servo_cmd | sync_cmd) & ~param_ff[`SSC_P_POSCODER];
   assign er05 = orient_cmd & ~param_ff[`SSC_P_ORIENT_OPT];
   assign er06 = low_winding_sel & ~param_ff[`SSC_P_SWITCH_OPT];
   assign er07 = contour_cmd & ~rotate_any;
   assign er08 = servo_cmd & ~rotate_any;
   assign er09 = sync_cmd & ~rotate_any;
   assign er10 = clash & nxt_owner[0];
   assign er11 = clash & nxt_owner[1];
   assign er12 = clash & nxt_owner[2];
   assign er13 = clash & nxt_owner[3];
   assign er14 = fwd_rotate_cmd & rev_rotate_cmd;
   assign er15 = contour_cmd & param_ff[`SSC_P_DIFF_SPEED];

   // Several errors can fire at once; lowest number is reported first
   assign nxt_err_code = er01 ? `SSC_ER_01 :
                         er02 ? `SSC_ER_02 :
                         er03 ? `SSC_ER_03 :
                         er04 ? `SSC_ER_04 :
                         er05 ? `SSC_ER_05 :
                         er06 ? `SSC_ER_06 :
                         er07 ? `SSC_ER_07 :
                         er08 ? `SSC_ER_08 :
                         er09 ? `SSC_ER_09 :
                         er10 ? `SSC_ER_10 :
                         er11 ? `SSC_ER_11 :
                         er12 ? `SSC_ER_12 :
                         er13 ? `SSC_ER_13 :
                         er14 ? `SSC_ER_14 :
                         er15 ? `SSC_ER_15 : `SSC_ER_NONE;

   // Excitation is refused only for the errors that say so
   assign no_excite = er02 | er03 | er04;

   // Error code follows the live condition, so it clears once the cause goes
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         err_code_ff <= `SSC_ER_NONE;
      end else begin
         err_code_ff <= nxt_err_code;
      end
   end

   // ****************************************************************
   // Amplifier indicator
   // ****************************************************************
   // Indicator outputs, registered; no path to the controller side exists
   logic nxt_flag;
   assign nxt_flag = (nxt_err_code != `SSC_ER_NONE);
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         amp_err_code <= `SSC_ER_NONE;
         amp_err_flag <= 1'b0;
         motor_excite_en <= 1'b0;
      end else begin
         amp_err_code <= nxt_err_code;
         amp_err_flag <= nxt_flag;
         motor_excite_en <= ~no_excite;
      end
   end

   // ****************************************************************
   // Events and interrupt
   // ****************************************************************
   logic [`SSC_STAT_W-1:0] stat_ff;
   logic [`SSC_STAT_W-1:0] mask_ff;
   logic [`SSC_STAT_W-1:0] ev;
   logic [`SSC_STAT_W-1:0] w1c;
   logic [`SSC_STAT_W-1:0] nxt_stat;

   // New code appearing, and error going away, are the two events
   assign ev[`SSC_S_NEWERR] = (nxt_err_code != `SSC_ER_NONE) & (nxt_err_code != err_code_ff);
   assign ev[`SSC_S_CLEARED] = (nxt_err_code == `SSC_ER_NONE) & (err_code_ff != `SSC_ER_NONE);
   // Set beats clear so an event landing on the clear write is kept
   assign nxt_stat = (stat_ff & ~w1c) | ev;

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         stat_ff <= '0;
         irq <= 1'b0;
      end else begin
         stat_ff <= nxt_stat;
         irq <= |(nxt_stat & mask_ff);
      end
   end

   // ****************************************************************
   // AHB-Lite slave
   // ****************************************************************
   ssc_bus_t bus_ff;
   logic [11:0] addr_ff;
   logic addr_ph;
   logic hit_param;
   logic hit_stat;
   logic hit_mask;
   logic wr_param;
   logic wr_stat;
   logic wr_mask;
   logic [31:0] rd_mux;

   // Slave is always ready and always answers OKAY; unmapped reads give zero
   assign addr_ph = hsel & hready & htrans[1];
   assign hit_param = (addr_ff == `SSC_OFF_PARAM);
   assign hit_stat = (addr_ff == `SSC_OFF_STAT);
   assign hit_mask = (addr_ff == `SSC_OFF_MASK);
   assign wr_param = (bus_ff == SSC_BUS_WR) & hit_param;
   assign wr_stat = (bus_ff == SSC_BUS_WR) & hit_stat;
   assign wr_mask = (bus_ff == SSC_BUS_WR) & hit_mask;
   assign w1c = wr_stat ? hwdata[`SSC_STAT_W-1:0] : '0;

   // ****************************************************************
   // Read path
   // ****************************************************************
   logic hit_param_a;
   logic hit_err_a;
   logic hit_stat_a;
   logic hit_mask_a;
   assign hit_param_a = (haddr[11:0] == `SSC_OFF_PARAM);
   assign hit_err_a = (haddr[11:0] == `SSC_OFF_ERR);
   assign hit_stat_a = (haddr[11:0] == `SSC_OFF_STAT);
   assign hit_mask_a = (haddr[11:0] == `SSC_OFF_MASK);

   // Read data chosen in the address phase so it stands registered in the data phase
   always_comb begin
      if (hit_param_a) begin
         rd_mux = {16'h0000, param_ff};
      end else if (hit_err_a) begin
         rd_mux = {26'h0, amp_err_flag, err_code_ff};
      end else if (hit_stat_a) begin
         rd_mux = {30'h0, nxt_stat};
      end else if (hit_mask_a) begin
         rd_mux = {30'h0, mask_ff};
      end else begin
         rd_mux = 32'h00000000;
      end
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         bus_ff <= SSC_BUS_IDLE;
         addr_ff <= 12'h000;
      end else if (addr_ph) begin
         bus_ff <= hwrite ? SSC_BUS_WR : SSC_BUS_RD;
         addr_ff <= haddr[11:0];
      end else begin
         bus_ff <= SSC_BUS_IDLE;
      end
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         hrdata <= 32'h00000000;
      end else if (addr_ph & ~hwrite) begin
         hrdata <= rd_mux;
      end
   end

   // ****************************************************************
   // Software registers
   // ****************************************************************
   // Registers written by software; parameters steer the checks above
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         param_ff <= `SSC_PARAM_RST;
         mask_ff <= `SSC_MASK_RST;
      end else begin
         if (wr_param) begin
            param_ff <= hwdata[`SSC_PARAM_W-1:0];
         end
         if (wr_mask) begin
            mask_ff <= hwdata[`SSC_STAT_W-1:0];
         end
      end
   end

   // ****************************************************************
   // Bus response
   // ****************************************************************
   // Zero-wait slave; both handshake outputs are constant flops
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
   end

endmodule : ssc_checker

// File: tb/ssc_ctl_model.sv
// Controller model: drives the spindle command lines from a request word.
// Assumes the bench changes the request just after a rising edge.
`timescale 1ns/1ns
module ssc_ctl_model (
   input wire logic mclk,
   input wire logic [8:0] req,
   output logic [8:0] cmd = 9'h000
);
   // Updated once per scan, like a ladder output image
   // Drives only what is asked, so conflicting sets come from the bench
   always @(posedge mclk) begin
      cmd <= req;
   end
endmodule : ssc_ctl_model

// File: tb/ssc_checker_properties.sv
// Checker of the spindle command checker outputs against its command inputs.
// Assumes one clock domain; bound onto the checker module by the statement below.
`timescale 1ns/1ns
module ssc_checker_properties (
   input wire logic mclk,
   input wire logic nrst,
   input wire logic fwd_rotate_cmd,
   input wire logic rev_rotate_cmd,
   input wire logic emerg_stop_n,
   input wire logic machine_ready,
   input wire logic contour_cmd,
   input wire logic servo_cmd,
   input wire logic sync_cmd,
   input wire logic orient_cmd,
   input wire logic low_winding_sel,
   input wire logic hsel,
   input wire logic [4:0] amp_err_code,
   input wire logic amp_err_flag,
   input wire logic motor_excite_en
);
   // Combined command view; bus traffic may change parameters
   wire logic rot = fwd_rotate_cmd | rev_rotate_cmd;
   wire logic [8:0] cmds = {low_winding_sel, orient_cmd, sync_cmd, servo_cmd, contour_cmd,
      machine_ready, emerg_stop_n, rev_rotate_cmd, fwd_rotate_cmd};
   default clocking @(posedge mclk); endclocking
   default disable iff (!nrst);
   property p_flag; amp_err_flag == (amp_err_code != 5'h00); endproperty
   a_flag: assert property (p_flag) else $error("flag and code disagree");
   property p_rot01; rot && !emerg_stop_n |=> amp_err_code == 5'h01; endproperty
   a_rot01: assert property (p_rot01) else $error("rotation without release not code 1");
   property p_both; fwd_rotate_cmd && rev_rotate_cmd |=> amp_err_flag; endproperty
   a_both: assert property (p_both) else $error("both directions not flagged");
   property p_excite; $past(nrst) && !motor_excite_en |-> amp_err_flag; endproperty
   a_excite: assert property (p_excite) else $error("excitation refused silently");
   property p_norot; (contour_cmd || servo_cmd || sync_cmd) && !rot |=> amp_err_flag; endproperty
   a_norot: assert property (p_norot) else $error("mode without rotation not flagged");
   property p_contour; contour_cmd && (servo_cmd || sync_cmd || orient_cmd) |=> amp_err_flag; endproperty
   a_contour: assert property (p_contour) else $error("contour conflict not flagged");
   property p_other; (servo_cmd && (sync_cmd || orient_cmd)) || (sync_cmd && orient_cmd) |=> amp_err_flag;
   endproperty
   a_other: assert property (p_other) else $error("mode conflict not flagged");
   property p_hold; (!hsel && $stable(cmds))[*3] |=> $stable(amp_err_code); endproperty
   a_hold: assert property (p_hold) else $error("code moved with steady cause");
endmodule : ssc_checker_properties
bind ssc_checker ssc_checker_properties u_props (.mclk, .nrst, .fwd_rotate_cmd, .rev_rotate_cmd,
   .emerg_stop_n, .machine_ready, .contour_cmd, .servo_cmd, .sync_cmd, .orient_cmd,
   .low_winding_sel, .hsel, .amp_err_code, .amp_err_flag, .motor_excite_en);

// File: tb/ssc_checker_tb_top.sv
// Testbench of the spindle command checker: bus tasks plus command cases.
// Assumes the register header and a controller model beside the design.
`timescale 1ns/1ns
`include "ssc_regs.svh"
module ssc_checker_tb_top;
   logic mclk = 0;
   logic nrst = 0;
   logic hsel = 0;
   logic hwrite = 0;
   logic [1:0] htrans = 2'h0;
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   logic [8:0] req = 9'h000;
   wire logic [8:0] cmd;
   wire logic [31:0] hrdata;
   wire logic hready, hresp, flag, excite, irq;
   wire logic [4:0] code;
   int err_count = 0;
   int comparisons = 0;
   always #20 mclk = ~mclk;
   ssc_ctl_model u_ctl (.mclk, .req, .cmd);
   ssc_checker dut (.mclk, .nrst, .fwd_rotate_cmd(cmd[0]), .rev_rotate_cmd(cmd[1]), .emerg_stop_n(cmd[2]),
      .machine_ready(cmd[3]), .contour_cmd(cmd[4]), .servo_cmd(cmd[5]), .sync_cmd(cmd[6]),
      .orient_cmd(cmd[7]), .low_winding_sel(cmd[8]), .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
      .hwdata, .hready, .hrdata, .hreadyout(hready), .hresp, .amp_err_code(code), .amp_err_flag(flag),
      .motor_excite_en(excite), .irq);
   task check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         err_count++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task test_done;
      $display("comparisons %0d err_count %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : test_done
   // Bounded wait for ready; a hang ends the run
   task wait_rdy;
      int n;
      n = 0;
      do begin
         @(posedge mclk);
         n++;
      end while (hready !== 1'b1 && n < 50);
      if (hready !== 1'b1) begin
         err_count++;
         test_done;
      end
   endtask : wait_rdy
   task bus(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
      hsel <= 1'b1;
      haddr <= {20'h00000, a};
      htrans <= 2'h2;
      hwrite <= wr;
      wait_rdy;
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      wait_rdy;
      q = hrdata;
   endtask : bus
   task rd(input logic [11:0] a, input logic [31:0] e);
      logic [31:0] q;
      bus(1'b0, a, 32'h0, q);
      check(q, e);
   endtask : rd
   // Parameter write, command set, then code, flag and excitation
   task run(input logic [15:0] p, input logic [8:0] c, input logic [4:0] e);
      logic [31:0] q;
      bus(1'b1, `SSC_OFF_PARAM, {16'h0000, p}, q);
      req <= c;
      repeat (3) @(posedge mclk);
      check({27'h0, code}, {27'h0, e});
      check({30'h0, flag, excite}, {30'h0, e != 5'h00, !(e inside {5'h02, 5'h03, 5'h04})});
   endtask : run
   initial begin
      logic [31:0] q;
      repeat (10) @(posedge mclk);
      nrst <= 1'b1;
      @(posedge mclk);
      rd(`SSC_OFF_PARAM, 32'h0);
      rd(`SSC_OFF_MASK, 32'h0);
      run(16'h803b, 9'h009, 5'h01);
      run(16'h803b, 9'h005, 5'h01);
      run(16'h803a, 9'h005, 5'h00);
      run(16'h403b, 9'h00d, 5'h02);
      run(16'h403f, 9'h00d, 5'h00);
      run(16'h8039, 9'h01d, 5'h03);
      run(16'h8033, 9'h02d, 5'h04);
      run(16'h802b, 9'h08d, 5'h05);
      run(16'h801b, 9'h10d, 5'h06);
      run(16'h803b, 9'h01c, 5'h07);
      run(16'h803b, 9'h02c, 5'h08);
      run(16'h803b, 9'h04c, 5'h09);
      run(16'h803b, 9'h03d, 5'h0a);
      run(16'h803b, 9'h06d, 5'h0b);
      run(16'h803b, 9'h0ad, 5'h0b);
      run(16'h803b, 9'h0cd, 5'h0d);
      run(16'h803b, 9'h04d, 5'h00);
      run(16'h803b, 9'h0cd, 5'h0c);
      run(16'h807b, 9'h01d, 5'h0f);
      run(16'h803b, 9'h00f, 5'h0e);
      rd(`SSC_OFF_ERR, 32'h2e);
      run(16'h803b, 9'h00d, 5'h00);
      rd(`SSC_OFF_STAT, 32'h3);
      check({31'h0, irq}, 32'h0);
      bus(1'b1, `SSC_OFF_MASK, 32'h1, q);
      repeat (2) @(posedge mclk);
      check({31'h0, irq}, 32'h1);
      bus(1'b1, `SSC_OFF_STAT, 32'h3, q);
      repeat (2) @(posedge mclk);
      check({31'h0, irq}, 32'h0);
      rd(`SSC_OFF_STAT, 32'h0);
      rd(12'h010, 32'h0);
      // Mid-run reset clears a standing error; commands dropped before release
      req <= 9'h00f;
      repeat (3) @(posedge mclk);
      check({27'h0, code}, 32'he);
      nrst <= 1'b0;
      req <= 9'h000;
      repeat (2) @(posedge mclk);
      check({28'h0, flag, excite, hready, hresp}, 32'h2);
      nrst <= 1'b1;
      repeat (2) @(posedge mclk);
      check({28'h0, flag, excite, hready, hresp}, 32'h6);
      rd(`SSC_OFF_PARAM, 32'h0);
      test_done;
   end
endmodule : ssc_checker_tb_top
